// *** logic/tap_alarm_pin.sv ***
// Thermal alarm pin block: input monitoring, full speed on alarm,
// time-limit alert, critical temperature output and speed sense grouping.
// Assumes one clock, synchronous inputs and an external wire resolving
// the open-drain pin from thermal_alarm_pin_oe.
`timescale 1ns/100ps
`include "tap_params.svh"

module tap_alarm_pin #(
	parameter int NUM_DRIVES = 3,
	parameter int NUM_SENSES = 4,
	parameter int TICK_CYCLES = `TAP_TIMER_LSB_NS / `TAP_CLK_PERIOD_NS
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire tap_pkg::tap_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// Open-drain alarm pin, active low
	input wire logic thermal_alarm_pin_in,
	output logic thermal_alarm_pin_out,
	output logic thermal_alarm_pin_oe,
	// Temperature samples, one per monitoring cycle per channel
	input wire tap_pkg::tap_temp_sample_t temp_sample,
	// Programmed fan state per drive
	input wire tap_pkg::tap_fan_setting_t [NUM_DRIVES-1:0] fan_setting,
	// Applied duty per drive, index 0 is fan_drive_1
	output logic [NUM_DRIVES-1:0][7:0] fan_drive_duty,
	// Drive each speed input is measured against, index 0 is speed_sense_1
	output logic [NUM_SENSES-1:0][1:0] speed_sense_drive,
	// Alert request toward the alert pin logic, active high
	output logic alarm_alert
);

	// ****************************************************************
	// Limitations
	// ****************************************************************
	// The pin is taken as already synchronous; a raw board pin needs a
	// two-stage synchroniser ahead of this block.
	// Our own pull is seen on the shared wire, so an overheated channel
	// also runs the timer and can full_speed_on_alarm the fans.
	// The decode knows three drives; NUM_SENSES below two breaks grouping.

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed
	{
		logic [2:0][7:0] temp_config;
		logic [7:0] acoustics_config_1;
		logic [2:0][7:0] critical_limit;
		logic [7:0] interrupt_mask_2;
		logic [7:0] config_3;
		logic [7:0] alarm_time_limit;
		logic alarm_time_exceeded_flag;
		logic [2:0] channel_over;
		logic [NUM_DRIVES-1:0][7:0] duty;
		logic [NUM_SENSES-1:0][1:0] sense_drive;
		logic [7:0] rdata;
	} tap_state_t;

	tap_state_t st;
	tap_state_t next_st;

	logic alarm_asserted;
	logic timer_clear;
	logic [7:0] timer_value;
	logic [1:0] wr_channel;
	logic wr_is_config;
	logic wr_is_limit;
	logic full_speed_on_alarm_active;
	logic [NUM_DRIVES-1:0] drive_full_speed_on_alarm;
	logic [2:0] channel_pull;
	logic sample_ok;
	logic sample_hot;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// Channel index of a per-channel config offset, 2'b11 when none
	function automatic logic [1:0] config_index(input logic [7:0] addr);
		if (addr == `TAP_OFS_REMOTE1_TEMP_CONFIG)
			return 2'b00;
		else if (addr == `TAP_OFS_LOCAL_TEMP_CONFIG)
			return 2'b01;
		else if (addr == `TAP_OFS_REMOTE2_TEMP_CONFIG)
			return 2'b10;
		else
			return 2'b11;
	endfunction : config_index

	// Channel index of a critical limit offset, 2'b11 when none
	function automatic logic [1:0] limit_index(input logic [7:0] addr);
		if (addr == `TAP_OFS_REMOTE1_CRITICAL_LIMIT)
			return 2'b00;
		else if (addr == `TAP_OFS_LOCAL_CRITICAL_LIMIT)
			return 2'b01;
		else if (addr == `TAP_OFS_REMOTE2_CRITICAL_LIMIT)
			return 2'b10;
		else
			return 2'b11;
	endfunction : limit_index

	// A fan counts as running only when it would spin without the alarm
	function automatic logic fan_running(input tap_pkg::tap_fan_setting_t f);
		return f.auto_mode ? f.above_min : (f.duty != `TAP_DUTY_OFF);
	endfunction : fan_running

	// ****************************************************************
	// Alarm input qualification and timer
	// ****************************************************************

	// Pin level includes our own drive, as on the shared wire
	assign alarm_asserted = st.config_3[`TAP_BIT_ALARM_PIN_ENABLE] & ~thermal_alarm_pin_in;

	// Reading the timer clears it
	assign timer_clear = reg_req.rd && (reg_req.addr == `TAP_OFS_ALARM_TIMER);

	tap_alarm_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.sys_clk(sys_clk),
		.reset(reset),
		.active(alarm_asserted),
		.clear(timer_clear),
		.value(timer_value)
	);

	assign wr_channel = config_index(reg_req.addr);
	assign wr_is_config = reg_req.wr && (wr_channel != 2'b11);
	assign wr_is_limit = reg_req.wr && (limit_index(reg_req.addr) != 2'b11);

	// ****************************************************************
	// Per-drive and per-channel terms
	// ****************************************************************

	// Full_speed_on_alarm needs both the mode bit and a qualified assertion
	assign full_speed_on_alarm_active = st.config_3[`TAP_BIT_FULL_SPEED_ON_ALARM] & alarm_asserted;

	// A stopped fan is left alone, so an alarm never starts it
	generate
		for (genvar dv = 0; dv < NUM_DRIVES; dv++)
		begin : g_drive_full_speed_on_alarm
			assign drive_full_speed_on_alarm[dv] = full_speed_on_alarm_active & fan_running(fan_setting[dv]);
		end
	endgenerate

	// One pull request per enabled channel; any of them holds the wire
	generate
		for (genvar ch = 0; ch < 3; ch++)
		begin : g_channel_pull
			assign channel_pull[ch] = st.channel_over[ch]
				& st.temp_config[ch][`TAP_BIT_ALARM_OUT_ENABLE];
		end
	endgenerate

	// Channel code three has no limit register and is dropped
	assign sample_ok = temp_sample.valid && (temp_sample.channel != 2'b11);

	// Strictly above four times the limit: a quarter degree over trips
	assign sample_hot = temp_sample.value
		> {st.critical_limit[temp_sample.channel], 2'b00};

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_st = st;

		// Register writes, address decode; one register per strobe,
		// so the chain order is for reading only. Unmapped offsets
		// fall through and are dropped without any error sign.
		if (wr_is_config)
			next_st.temp_config[wr_channel] = reg_req.wdata;
		else if (wr_is_limit)
			next_st.critical_limit[limit_index(reg_req.addr)] = reg_req.wdata;
		else if (reg_req.wr && reg_req.addr == `TAP_OFS_ACOUSTICS_CONFIG_1)
			next_st.acoustics_config_1 = reg_req.wdata;
		else if (reg_req.wr && reg_req.addr == `TAP_OFS_INTERRUPT_MASK_2)
			next_st.interrupt_mask_2 = reg_req.wdata;
		else if (reg_req.wr && reg_req.addr == `TAP_OFS_CONFIG_3)
			next_st.config_3 = reg_req.wdata;
		else if (reg_req.wr && reg_req.addr == `TAP_OFS_ALARM_TIME_LIMIT)
			next_st.alarm_time_limit = reg_req.wdata;
		else if (reg_req.wr && reg_req.addr == `TAP_OFS_ALARM_STATUS
			&& reg_req.wdata[`TAP_BIT_ALARM_TIME_EXCEEDED])
			next_st.alarm_time_exceeded_flag = 1'b0; // Write one to clear

		// Set after the clear so a same-cycle event is kept
		if (timer_value > st.alarm_time_limit)
			next_st.alarm_time_exceeded_flag = 1'b1;

		// Channel judged only when its sample arrives, so it holds until that channel's next sample
		if (sample_ok)
		begin
			if (sample_hot)
				next_st.channel_over[temp_sample.channel] = 1'b1;
			else
				next_st.channel_over[temp_sample.channel] = 1'b0;
		end

		// Applied duty per drive
		for (int d = 0; d < NUM_DRIVES; d++)
		begin
			if (drive_full_speed_on_alarm[d])
				next_st.duty[d] = `TAP_DUTY_FULL;
			else
				next_st.duty[d] = fan_setting[d].duty;
		end

		// Speed input grouping; inputs beyond the second share the third drive
		for (int s = 0; s < NUM_SENSES; s++)
		begin
			if (s >= 2)
				next_st.sense_drive[s] = 2'b10;
			else if (s == 1 && st.acoustics_config_1[`TAP_BIT_SENSE_GROUPING])
				next_st.sense_drive[s] = 2'b10;
			else
				next_st.sense_drive[s] = 2'(s);
		end

		// Read data, one cycle after the strobe; unmapped reads zero
		next_st.rdata = 8'h00;
		if (reg_req.rd)
		begin
			if (config_index(reg_req.addr) != 2'b11)
				next_st.rdata = st.temp_config[config_index(reg_req.addr)];
			else if (limit_index(reg_req.addr) != 2'b11)
				next_st.rdata = st.critical_limit[limit_index(reg_req.addr)];
			else if (reg_req.addr == `TAP_OFS_ACOUSTICS_CONFIG_1)
				next_st.rdata = st.acoustics_config_1;
			else if (reg_req.addr == `TAP_OFS_INTERRUPT_MASK_2)
				next_st.rdata = st.interrupt_mask_2;
			else if (reg_req.addr == `TAP_OFS_CONFIG_3)
				next_st.rdata = st.config_3;
			else if (reg_req.addr == `TAP_OFS_ALARM_TIMER)
				next_st.rdata = timer_value;
			else if (reg_req.addr == `TAP_OFS_ALARM_TIME_LIMIT)
				next_st.rdata = st.alarm_time_limit;
			else if (reg_req.addr == `TAP_OFS_ALARM_STATUS)
				next_st.rdata = 8'(st.alarm_time_exceeded_flag) << `TAP_BIT_ALARM_TIME_EXCEEDED;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			// Clear everything, then patch registers with other defaults
			st <= '0;
			st.critical_limit <= {3{`TAP_RST_CRITICAL_LIMIT}};
			st.temp_config <= {3{`TAP_RST_CONFIG}};
			st.acoustics_config_1 <= `TAP_RST_CONFIG;
			st.interrupt_mask_2 <= `TAP_RST_CONFIG;
			st.config_3 <= `TAP_RST_CONFIG;
			st.alarm_time_limit <= `TAP_RST_ALARM_TIME_LIMIT;
			st.sense_drive <= {2'b10, 2'b10, 2'b01, 2'b00};
		end
		else
			st <= next_st;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Alert follows the sticky flag; the mask never stops the flag itself
	assign alarm_alert = st.alarm_time_exceeded_flag
		& ~st.interrupt_mask_2[`TAP_BIT_ALARM_TIME_MASK];

	// Only ever pull low; otherwise release the wire
	assign thermal_alarm_pin_out = 1'b0;
	assign thermal_alarm_pin_oe = |channel_pull;

	// Data outputs straight from the state flops
	assign fan_drive_duty = st.duty;
	assign speed_sense_drive = st.sense_drive;
	assign reg_rdata = st.rdata;

endmodule : tap_alarm_pin

// *** logic/tap_alarm_timer.sv ***
// Cumulative alarm assertion timer, cleared when software reads it.
// Assumes active is already qualified by the pin enable and synchronous.
`timescale 1ns/100ps
`include "tap_params.svh"

module tap_alarm_timer #(
	parameter int TICK_CYCLES = `TAP_TIMER_LSB_NS / `TAP_CLK_PERIOD_NS
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Control
	input wire logic active,
	input wire logic clear,
	// Result
	output logic [7:0] value
);

	tap_pkg::tap_timer_state_t st;
	tap_pkg::tap_timer_state_t next_st;

	// Accumulate whole resolution steps while the pin is asserted
	always_comb
	begin
		next_st = st;
		if (clear)
		begin
			// A read during assertion restarts with bit 0 already set
			next_st.tick_count = 32'h00000000;
			next_st.units = 8'h00;
			next_st.seen = active;
		end
		else if (active)
		begin
			next_st.seen = 1'b1;
			if (st.tick_count >= 32'(TICK_CYCLES - 1))
			begin
				next_st.tick_count = 32'h00000000;
				if (st.units != 8'hFF)
					next_st.units = st.units + 8'h01; // Saturates at full scale
			end
			else
				next_st.tick_count = st.tick_count + 32'h00000001;
		end
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	// Below two steps only the first-assertion marker shows
	assign value = (st.units >= 8'h02) ? st.units : {7'h00, st.seen};

endmodule : tap_alarm_timer

// *** logic/tap_params.svh ***
// Constants of the thermal alarm pin block: register offsets, field
// positions, reset values and timing figures.
// Assumes the includer compiles it once per unit; the guard covers repeats.
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TAP_OFS_REMOTE1_TEMP_CONFIG 8'h5F
`define TAP_OFS_LOCAL_TEMP_CONFIG 8'h60
`define TAP_OFS_REMOTE2_TEMP_CONFIG 8'h61
`define TAP_OFS_ACOUSTICS_CONFIG_1 8'h62
`define TAP_OFS_REMOTE1_CRITICAL_LIMIT 8'h6A
`define TAP_OFS_LOCAL_CRITICAL_LIMIT 8'h6B
`define TAP_OFS_REMOTE2_CRITICAL_LIMIT 8'h6C
`define TAP_OFS_INTERRUPT_MASK_2 8'h75
`define TAP_OFS_CONFIG_3 8'h78
`define TAP_OFS_ALARM_TIMER 8'h79
`define TAP_OFS_ALARM_TIME_LIMIT 8'h7A
`define TAP_OFS_ALARM_STATUS 8'h80

// ****************************************************************
// Field positions
// ****************************************************************
`define TAP_BIT_ALARM_PIN_ENABLE 1
`define TAP_BIT_FULL_SPEED_ON_ALARM 2
`define TAP_BIT_ALARM_OUT_ENABLE 3
`define TAP_BIT_SENSE_GROUPING 4
`define TAP_BIT_ALARM_TIME_MASK 5
`define TAP_BIT_ALARM_TIME_EXCEEDED 5

// ****************************************************************
// Reset values and duty levels
// ****************************************************************
`define TAP_RST_CONFIG 8'h00
`define TAP_RST_CRITICAL_LIMIT 8'h64
`define TAP_RST_ALARM_TIME_LIMIT 8'h00
`define TAP_DUTY_FULL 8'hFF
`define TAP_DUTY_OFF 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define TAP_CLK_PERIOD_NS 20
`define TAP_TIMER_LSB_NS 22760000

`endif

// *** logic/tap_pkg.sv ***
// Types shared by the thermal alarm pin block and its alarm timer.
// Assumes tap_params.svh supplies the numeric constants.
package tap_pkg;

	// ****************************************************************
	// Temperature channels
	// ****************************************************************
	typedef enum logic [1:0]
	{
		TAP_CH_REMOTE1 = 2'b00,
		TAP_CH_LOCAL = 2'b01,
		TAP_CH_REMOTE2 = 2'b10
	} tap_channel_t;

	// One measured temperature, quarter degree resolution
	typedef struct packed
	{
		logic valid;
		tap_channel_t channel;
		logic [9:0] value;
	} tap_temp_sample_t;

	// Programmed fan state for one drive channel
	typedef struct packed
	{
		logic [7:0] duty;
		logic auto_mode;
		logic above_min;
	} tap_fan_setting_t;

	// Register bus request
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tap_reg_req_t;

	// Alarm timer state
	typedef struct packed
	{
		logic [31:0] tick_count;
		logic [7:0] units;
		logic seen;
	} tap_timer_state_t;

endpackage : tap_pkg

// *** sim/tap_alarm_pin_chk.sv ***
// Checker of the alarm pin block, bound to its top module.
// Assumes the register map as the block decodes it.
`timescale 1ns/100ps

module tap_alarm_pin_chk #(
	parameter int NUM_DRIVES = 3,
	parameter int NUM_SENSES = 4
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Watched ports
	input wire tap_pkg::tap_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic thermal_alarm_pin_in,
	input wire logic thermal_alarm_pin_out,
	input wire logic thermal_alarm_pin_oe,
	input wire tap_pkg::tap_temp_sample_t temp_sample,
	input wire tap_pkg::tap_fan_setting_t [NUM_DRIVES-1:0] fan_setting,
	input wire logic [NUM_DRIVES-1:0][7:0] fan_drive_duty,
	input wire logic [NUM_SENSES-1:0][1:0] speed_sense_drive,
	input wire logic alarm_alert
);
	logic [2:1] c3;
	logic [2:0] en;
	logic [2:0][7:0] lim;
	logic m5;
	logic tz;

	// Shadow of the registers the rules depend on
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			c3 <= 2'h0;
			en <= 3'h0;
			lim <= {3{8'h64}};
			m5 <= 1'b0;
			tz <= 1'b1;
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				8'h5F: en[0] <= reg_req.wdata[3];
				8'h60: en[1] <= reg_req.wdata[3];
				8'h61: en[2] <= reg_req.wdata[3];
				8'h6A: lim[0] <= reg_req.wdata;
				8'h6B: lim[1] <= reg_req.wdata;
				8'h6C: lim[2] <= reg_req.wdata;
				8'h75: m5 <= reg_req.wdata[5];
				8'h78: c3 <= reg_req.wdata[2:1];
				8'h7A: tz <= (reg_req.wdata == 8'h00);
				default: ;
			endcase
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_pin_open: assert property (!thermal_alarm_pin_out)
		else $error("alarm pin driven high");
	a_sense_map: assert property (speed_sense_drive[0] == 2'h0 &&
		speed_sense_drive[2] == 2'h2 && speed_sense_drive[3] == 2'h2)
		else $error("fixed speed input mapping wrong");
	a_sync_group: assert property (reg_req.wr && reg_req.addr == 8'h62 &&
		reg_req.wdata[4] |-> ##2 speed_sense_drive[1] == 2'h2)
		else $error("grouping not applied");
	a_full_speed_on_alarm_full: assert property (c3 == 2'h3 && !thermal_alarm_pin_in &&
		fan_setting[0].duty != 8'h00 && !fan_setting[0].auto_mode
		|=> fan_drive_duty[0] == 8'hFF) else $error("no full duty on alarm");
	a_duty_follow: assert property (c3 != 2'h3
		|=> fan_drive_duty[0] == $past(fan_setting[0].duty))
		else $error("duty does not follow setting");
	a_hot_drive: assert property (temp_sample.valid && en[temp_sample.channel] &&
		temp_sample.value > {lim[temp_sample.channel], 2'h0} |=> thermal_alarm_pin_oe)
		else $error("hot channel did not pull pin");
	a_oe_cause: assert property (thermal_alarm_pin_oe |-> en != 3'h0)
		else $error("pin pulled with no channel enabled");
	a_oe_hold: assert property (thermal_alarm_pin_oe && !temp_sample.valid &&
		!reg_req.wr |=> thermal_alarm_pin_oe) else $error("pin released early");
	a_alert_mask: assert property (alarm_alert |-> !m5)
		else $error("masked alert raised");
	a_zero_limit: assert property (c3[1] && !thermal_alarm_pin_in && tz && !m5
		|-> ##[1:4] alarm_alert) else $error("no alert on first assertion");
	a_limit_read: assert property (reg_req.rd && reg_req.addr == 8'h6B
		|=> reg_rdata == lim[1]) else $error("limit readback wrong");
endmodule : tap_alarm_pin_chk

bind tap_alarm_pin tap_alarm_pin_chk #(.NUM_DRIVES(NUM_DRIVES), .NUM_SENSES(NUM_SENSES)) chk (
	.sys_clk(sys_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.thermal_alarm_pin_in(thermal_alarm_pin_in), .thermal_alarm_pin_out(thermal_alarm_pin_out),
	.thermal_alarm_pin_oe(thermal_alarm_pin_oe), .temp_sample(temp_sample),
	.fan_setting(fan_setting), .fan_drive_duty(fan_drive_duty),
	.speed_sense_drive(speed_sense_drive), .alarm_alert(alarm_alert));

// *** sim/tap_alarm_src.sv ***
// Model of the far-side alarm source that pulls the shared alarm wire low.
// Assumes the bench resolves the wire from every pull and a pull-up.
`timescale 1ns/100ps

module tap_alarm_src (
	// Clock
	input wire logic sys_clk,
	// Bench request, pull while high
	input wire logic hold,
	// Pull on the shared wire
	output logic pull_low
);
	// Registered like a hot output of a processor
	always_ff @(posedge sys_clk)
		pull_low <= hold;
endmodule : tap_alarm_src

// *** sim/test_tap_alarm_pin.sv ***
// Testbench of the alarm pin block with a far-side alarm source.
// Assumes the register port answers a read in the next cycle.
`timescale 1ns/100ps

module test_tap_alarm_pin;
	logic sys_clk, reset, hold, pull_low, oe, alert;
	logic [7:0] rdata, ssd;
	logic [23:0] duty;
	tap_pkg::tap_reg_req_t req;
	tap_pkg::tap_temp_sample_t ts;
	tap_pkg::tap_fan_setting_t [2:0] fs;
	int n_mismatch = 0;
	int n_compared = 0;

	// Open-drain wire with pull-up
	wire logic pin = !(oe || pull_low);

	tap_alarm_pin #(.TICK_CYCLES(4)) uut (.sys_clk(sys_clk), .reset(reset), .reg_req(req),
		.reg_rdata(rdata), .thermal_alarm_pin_in(pin), .thermal_alarm_pin_out(),
		.thermal_alarm_pin_oe(oe), .temp_sample(ts), .fan_setting(fs),
		.fan_drive_duty(duty), .speed_sense_drive(ssd), .alarm_alert(alert));
	tap_alarm_src src (.sys_clk(sys_clk), .hold(hold), .pull_low(pull_low));

	// 50 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, d);
		@(posedge sys_clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk) req.wr <= 1'b0;
	endtask : wr

	// Read data only stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a, e);
		@(posedge sys_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk) req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd

	task automatic pulse(input logic [7:0] cfg, input logic [23:0] e);
		wr(8'h78, cfg);
		@(posedge sys_clk) hold <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk(duty, e);
		@(posedge sys_clk) hold <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : pulse

	task automatic samp(input logic [1:0] ch, input logic [9:0] v, input logic e);
		@(posedge sys_clk) ts <= '{1'b1, tap_pkg::tap_channel_t'(ch), v};
		@(posedge sys_clk) ts.valid <= 1'b0;
		@(posedge sys_clk) #1 chk(oe, e);
	endtask : samp

	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		req = '0;
		hold = 1'b0;
		ts = '0;
		fs = {10'h000, 10'h043, 10'h100}; // Off, auto 0x10 running, manual 0x40
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		rd(8'h78, 8'h00);
		rd(8'h6B, 8'h64);
		rd(8'h10, 8'h00);
		chk(ssd, 8'hA4);
		wr(8'h62, 8'h10);
		repeat (2) @(posedge sys_clk);
		#1 chk(ssd, 8'hA8);
		wr(8'h62, 8'h00);
		wr(8'h6B, 8'h50);
		rd(8'h6B, 8'h50);
		pulse(8'h00, 24'h001040);
		pulse(8'h02, 24'h001040);
		pulse(8'h06, 24'h00FFFF);
		fs[1].above_min <= 1'b0;
		pulse(8'h06, 24'h0010FF);
		#1 chk(alert, 1'b1);
		rd(8'h80, 8'h20);
		wr(8'h75, 8'h20);
		#1 chk(alert, 1'b0);
		rd(8'h79, 8'h03);
		rd(8'h79, 8'h00);
		wr(8'h80, 8'h20);
		rd(8'h80, 8'h00);
		wr(8'h7A, 8'h01);
		pulse(8'h02, 24'h001040);
		rd(8'h80, 8'h00);
		pulse(8'h02, 24'h001040);
		rd(8'h80, 8'h20);
		wr(8'h78, 8'h00);
		wr(8'h5F, 8'h08);
		wr(8'h6A, 8'h50);
		samp(2'h1, 10'h3FF, 1'b0);
		samp(2'h0, 10'h140, 1'b0);
		samp(2'h0, 10'h141, 1'b1);
		repeat (20) @(posedge sys_clk);
		#1 chk(oe, 1'b1);
		samp(2'h0, 10'h141, 1'b1);
		samp(2'h0, 10'h140, 1'b0);
		end_sim();
	end
endmodule : test_tap_alarm_pin
